// *** inc/fsr_pkg.sv ***
`default_nettype none
package fsr_pkg;
  // ----------------------------------------------------------------
  // host port map
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 10;
  localparam logic [9:0]  ADDR_STATUS_A   = 10'h3F0;
  localparam logic [9:0]  ADDR_STATUS_B   = 10'h3F1;
  localparam logic [9:0]  ADDR_OUT_CTRL   = 10'h3F2;
  localparam logic [9:0]  ADDR_DIG_INPUT  = 10'h3F7;
  localparam logic [7:0]  DATA_ZERO       = 8'h00;

  // ----------------------------------------------------------------
  // drive_output_control fields
  // ----------------------------------------------------------------
  localparam int          CTRL_W          = 6;
  localparam logic [5:0]  CTRL_RESET      = 6'h00;
  localparam int          CTRL_SEL_LO     = 0;
  localparam int          CTRL_SEL_HI     = 1;
  localparam int          CTRL_SOFT_RST_N = 2;
  localparam int          CTRL_DMA_GATE   = 3;
  localparam int          CTRL_MOTOR0     = 4;
  localparam int          CTRL_MOTOR1     = 5;
  localparam logic [1:0]  SEL_DRIVE0      = 2'h0;
  localparam logic [1:0]  SEL_DRIVE1      = 2'h1;

  // ----------------------------------------------------------------
  // status layout modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FSR_MODE_AT      = 2'b00,
    FSR_MODE_PRIMARY = 2'b01,
    FSR_MODE_ALT     = 2'b10
  } fsr_mode_t;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          SOFT_RST_MIN_NS = 100;
  localparam int          SOFT_RST_CYC    =
    (SOFT_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RST_CNT_W       = 2;
  localparam logic [1:0]  RST_CNT_LOAD    = 2'(SOFT_RST_CYC);
  localparam logic [1:0]  RST_CNT_ZERO    = 2'h0;
  localparam logic [1:0]  RST_CNT_ONE     = 2'h1;
endpackage
`default_nettype wire

// *** inc/fsr_pin_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// filtered pin level plus one-cycle edge pulses
interface fsr_pin_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// *** logic/fsr_pin_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module fsr_pin_sync
  import fsr_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b1
) (
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rstn,
  // raw pin
  input  wire logic i_pin,
  // filtered result
  fsr_pin_if.src    pin
);
  logic stage1;
  logic stage2;
  logic stage3;

  // a change counts only once the second and third stages agree
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stage1 <= RESET_LEVEL;
      stage2 <= RESET_LEVEL;
      stage3 <= RESET_LEVEL;
    end else begin
      stage1 <= i_pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin.level <= RESET_LEVEL;
      pin.rise  <= 1'b0;
      pin.fall  <= 1'b0;
    end else begin
      pin.rise <= 1'b0;
      pin.fall <= 1'b0;
      if (stage2 == stage3 && stage3 != pin.level) begin
        pin.level <= stage3;
        pin.rise  <= stage3;
        pin.fall  <= ~stage3;
      end
    end
  end
endmodule // fsr_pin_sync
`default_nettype wire

// *** logic/fsr_evt_latch.sv ***
`timescale 1ns/10ps
`default_nettype none
module fsr_evt_latch (
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rstn,
  // event and clear
  input  wire logic i_set,
  input  wire logic i_clr,
  // latched flag
  output var  logic o_flag
);
  // set wins over clear so an event in the clearing cycle is kept
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_flag <= 1'b0;
    end else if (i_set) begin
      o_flag <= 1'b1;
    end else if (i_clr) begin
      o_flag <= 1'b0;
    end
  end
endmodule // fsr_evt_latch
`default_nettype wire

// *** logic/fsr_top.sv ***
`timescale 1ns/10ps
`default_nettype none
// What this block does
// (RULE1) at mode floats status A reads
// (RULE2) primary status A bit layout
// (RULE3) second drive bit reads one
// (RULE4) alternate status A inverted layout
// (RULE5) alternate step latch, cleared by input read
// (RULE6) bit seven shows interrupt, zero after reset
// (RULE7) at floats status B; primary bits 7:6 one
// (RULE8) primary motor bits mirror motor outputs
// (RULE9) read data toggle on inactive edge
// (RULE10) write data toggle on inactive edge
// (RULE11) primary bit5 copies select, bit2 write gate
// (RULE12) alternate bits 0,1,7 read one
// (RULE13) alternate write gate latch
// (RULE14) alternate read/write data latches
// (RULE15) alternate bits 6:5 show select outputs
// (RULE16) output register writable, zero at hard reset
// (RULE17) binary drive select with motor outputs
// (RULE18) bit2 low holds controller reset, min 100ns
// (RULE19) dma gate bit enables dma, irq pins
// (RULE20) primary mode keeps dma pins enabled
// (RULE21) motor bits drive outputs; bits 7:6 zero
// (RULE22) mode input selects layout and gating
module fsr_top
  import fsr_pkg::*;
(
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rstn,
  // configuration
  input  wire logic [1:0]        i_mode,
  // host port, single-cycle strobes on i_sys_clk
  input  wire logic [ADDR_W-1:0] i_host_addr,
  input  wire logic              i_host_rd,
  input  wire logic              i_host_wr,
  input  wire logic [7:0]        i_host_wdata,
  output logic      [7:0]        o_host_rdata,
  output logic                   o_host_rdata_oe,
  // controller core state, same clock
  input  wire logic              i_core_step,
  input  wire logic              i_core_dir_in,
  input  wire logic              i_core_head_side_select,
  input  wire logic              i_core_write_gate,
  input  wire logic              i_core_write_data,
  input  wire logic              i_core_floppy_irq_line,
  input  wire logic              i_core_dma_req,
  // drive pins in, asynchronous
  input  wire logic              i_track_zero_n,
  input  wire logic              i_index_pulse_n,
  input  wire logic              i_write_protect_n,
  input  wire logic              i_read_data_n,
  // drive pins out
  output logic                   o_drive_select_out0_n,
  output logic                   o_drive_select_out1_n,
  output logic                   o_motor_on_drive0_n,
  output logic                   o_motor_on_drive1_n,
  // controller reset and dma gating
  output logic                   o_soft_reset_n,
  output logic                   o_dma_pin_gate,
  output logic                   o_dma_req,
  output logic                   o_dma_req_oe,
  output logic                   o_floppy_irq_line,
  output logic                   o_floppy_irq_line_oe
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  fsr_pin_if trk_if ();
  fsr_pin_if idx_if ();
  fsr_pin_if wp_if ();
  fsr_pin_if rd_if ();

  fsr_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_trk (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_pin     (i_track_zero_n),
    .pin       (trk_if)
  );
  fsr_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_idx (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_pin     (i_index_pulse_n),
    .pin       (idx_if)
  );
  fsr_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_wp (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_pin     (i_write_protect_n),
    .pin       (wp_if)
  );
  fsr_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_rd (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_pin     (i_read_data_n),
    .pin       (rd_if)
  );

  // ----------------------------------------------------------------
  // decode and mode
  // ----------------------------------------------------------------
  fsr_mode_t  mode;
  logic       is_primary;
  logic       is_at;
  logic       wr_ctrl;
  logic       rd_dig_input;
  logic [5:0] ctrl;
  logic [1:0] rst_cnt;

  always_comb begin
    unique case (i_mode)
      FSR_MODE_PRIMARY: mode = FSR_MODE_PRIMARY;
      FSR_MODE_ALT:     mode = FSR_MODE_ALT;
      default: mode = FSR_MODE_AT;
    endcase
  end

  assign is_primary   = (mode == FSR_MODE_PRIMARY);                  // [RULE22]
  assign is_at        = (mode == FSR_MODE_AT);
  assign wr_ctrl      = i_host_wr && (i_host_addr == ADDR_OUT_CTRL);
  assign rd_dig_input = i_host_rd && (i_host_addr == ADDR_DIG_INPUT);

  // ----------------------------------------------------------------
  // drive_output_control and controller reset
  // ----------------------------------------------------------------
  // bits 7:6 are not stored, so they read zero
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl <= CTRL_RESET;                                           // [RULE16]
    end else if (wr_ctrl) begin
      ctrl <= i_host_wdata[CTRL_W-1:0];                             // [RULE16] [RULE21]
    end
  end

  // stretch the reset so two back-to-back writes still meet the minimum
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_cnt <= RST_CNT_LOAD;
    end else if (!ctrl[CTRL_SOFT_RST_N]) begin
      rst_cnt <= RST_CNT_LOAD;                                      // [RULE18]
    end else if (rst_cnt != RST_CNT_ZERO) begin
      rst_cnt <= rst_cnt - RST_CNT_ONE;
    end
  end

  logic next_soft_reset_n;
  assign next_soft_reset_n = ctrl[CTRL_SOFT_RST_N] && (rst_cnt == RST_CNT_ZERO);

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_soft_reset_n <= 1'b0;
    end else begin
      o_soft_reset_n <= next_soft_reset_n;                          // [RULE18]
    end
  end

  // ----------------------------------------------------------------
  // drive select and motor outputs
  // ----------------------------------------------------------------
  logic next_ds0_n;
  logic next_ds1_n;
  assign next_ds0_n = !(ctrl[CTRL_SEL_HI:CTRL_SEL_LO] == SEL_DRIVE0
                        && ctrl[CTRL_MOTOR0]);                      // [RULE17]
  assign next_ds1_n = !(ctrl[CTRL_SEL_HI:CTRL_SEL_LO] == SEL_DRIVE1
                        && ctrl[CTRL_MOTOR1]);                      // [RULE17]

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_drive_select_out0_n <= 1'b1;
      o_drive_select_out1_n <= 1'b1;
      o_motor_on_drive0_n   <= 1'b1;
      o_motor_on_drive1_n   <= 1'b1;
    end else begin
      o_drive_select_out0_n <= next_ds0_n;
      o_drive_select_out1_n <= next_ds1_n;
      o_motor_on_drive0_n   <= !ctrl[CTRL_MOTOR0];                  // [RULE21]
      o_motor_on_drive1_n   <= !ctrl[CTRL_MOTOR1];                  // [RULE21]
    end
  end

  // ----------------------------------------------------------------
  // dma and interrupt pin gating
  // ----------------------------------------------------------------
  logic next_gate;
  assign next_gate = is_primary || ctrl[CTRL_DMA_GATE];             // [RULE19] [RULE20]

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_dma_pin_gate       <= 1'b0;
      o_dma_req            <= 1'b0;
      o_dma_req_oe         <= 1'b0;
      o_floppy_irq_line    <= 1'b0;
      o_floppy_irq_line_oe <= 1'b0;
    end else begin
      o_dma_pin_gate       <= next_gate;
      o_dma_req            <= i_core_dma_req;
      o_dma_req_oe         <= next_gate;                            // [RULE19]
      o_floppy_irq_line    <= i_core_floppy_irq_line;
      o_floppy_irq_line_oe <= next_gate;                            // [RULE20]
    end
  end

  // ----------------------------------------------------------------
  // edge latches and toggles
  // ----------------------------------------------------------------
  logic step_q;
  logic write_gate_q;
  logic wdata_q;
  logic step_ff;
  logic write_gate_ff;
  logic rdata_ff;
  logic wdata_ff;
  logic rdata_tgl;
  logic wdata_tgl;
  logic wdata_fall;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      step_q  <= 1'b0;
      write_gate_q <= 1'b0;
      wdata_q <= 1'b0;
    end else begin
      step_q  <= i_core_step;
      write_gate_q <= i_core_write_gate;
      wdata_q <= i_core_write_data;
    end
  end

  assign wdata_fall = wdata_q && !i_core_write_data;

  fsr_evt_latch u_lat_step (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_set     (i_core_step && !step_q),                            // [RULE5]
    .i_clr     (rd_dig_input || !o_soft_reset_n),                   // [RULE5]
    .o_flag    (step_ff)
  );
  fsr_evt_latch u_lat_write_gate (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_set     (i_core_write_gate && !write_gate_q),                     // [RULE13]
    .i_clr     (rd_dig_input),
    .o_flag    (write_gate_ff)
  );
  // the read pin is active low, so its inactive edge is a rise
  fsr_evt_latch u_lat_rdata (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_set     (rd_if.rise),                                        // [RULE14]
    .i_clr     (rd_dig_input),
    .o_flag    (rdata_ff)
  );
  // deliberately not qualified by write gate
  fsr_evt_latch u_lat_wdata (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_set     (wdata_fall),                                        // [RULE14]
    .i_clr     (rd_dig_input),
    .o_flag    (wdata_ff)
  );

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_tgl <= 1'b0;
      wdata_tgl <= 1'b0;
    end else begin
      if (rd_if.rise) rdata_tgl <= !rdata_tgl;                      // [RULE9]
      if (wdata_fall) wdata_tgl <= !wdata_tgl;                      // [RULE10]
    end
  end

  // ----------------------------------------------------------------
  // status read mux
  // ----------------------------------------------------------------
  logic [7:0] stat_a;
  logic [7:0] stat_b;
  logic [7:0] next_rdata;
  logic       next_oe;

  always_comb begin
    if (is_primary) begin
      stat_a = {o_floppy_irq_line, 1'b1, i_core_step, trk_if.level,  // [RULE2] [RULE3]
                i_core_head_side_select, idx_if.level, wp_if.level, i_core_dir_in};
      stat_b = {2'b11, ctrl[CTRL_SEL_LO], wdata_tgl, rdata_tgl,     // [RULE7] [RULE11]
                i_core_write_gate, !o_motor_on_drive1_n, !o_motor_on_drive0_n}; // [RULE8]
    end else begin
      stat_a = {o_floppy_irq_line, o_dma_req, step_ff, !trk_if.level, // [RULE4] [RULE6]
                !i_core_head_side_select, !idx_if.level, !wp_if.level, !i_core_dir_in};
      stat_b = {1'b1, o_drive_select_out1_n, o_drive_select_out0_n, // [RULE12] [RULE15]
                wdata_ff, rdata_ff, write_gate_ff, 2'b11};
    end
  end

  always_comb begin
    next_rdata = DATA_ZERO;
    next_oe    = 1'b0;
    if (i_host_rd) begin
      unique case (i_host_addr)
        ADDR_STATUS_A: begin
          next_rdata = stat_a;
          next_oe    = !is_at;                                      // [RULE1]
        end
        ADDR_STATUS_B: begin
          next_rdata = stat_b;
          next_oe    = !is_at;                                      // [RULE7]
        end
        ADDR_OUT_CTRL: begin
          next_rdata = {2'b00, ctrl};                               // [RULE21]
          next_oe    = 1'b1;
        end
        default: begin
          next_rdata = DATA_ZERO;
          next_oe    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_host_rdata    <= DATA_ZERO;
      o_host_rdata_oe <= 1'b0;
    end else begin
      o_host_rdata    <= next_rdata;
      o_host_rdata_oe <= next_oe;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_rd_a;
    i_host_rd && i_host_addr == ADDR_STATUS_A;
  endsequence
  sequence s_rd_b;
    i_host_rd && i_host_addr == ADDR_STATUS_B;
  endsequence

  a_at_float_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [RULE1]
    s_rd_a and is_at |=> !o_host_rdata_oe)
    else $error("status A driven in at mode");
  a_drv2_one: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [RULE3]
    s_rd_a and is_primary |=> o_host_rdata_oe && o_host_rdata[6])
    else $error("second drive bit not one");
  a_irq_bit: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [RULE6]
    s_rd_a and !is_at |=> o_host_rdata[7] == $past(o_floppy_irq_line))
    else $error("interrupt bit mismatch");
  a_srb_fixed: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [RULE7]
    s_rd_b and is_primary |=> o_host_rdata[7:6] == 2'b11)
    else $error("status B top bits not one");
  a_ctrl_top_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [RULE21]
    i_host_rd && i_host_addr == ADDR_OUT_CTRL |=> o_host_rdata[7:6] == 2'b00)
    else $error("motor 2/3 bits not zero");
  a_rst_min_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [RULE18]
    $fell(o_soft_reset_n) |-> !o_soft_reset_n [*3])
    else $error("soft reset too short");
  a_drive0_act: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [RULE17]
    wr_ctrl && i_host_wdata == 8'h1C ##1 !wr_ctrl |=>
      !o_drive_select_out0_n && !o_motor_on_drive0_n && o_drive_select_out1_n)
    else $error("drive 0 not activated");
  a_primary_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [RULE20]
    is_primary |=> o_dma_req_oe && o_floppy_irq_line_oe)
    else $error("dma pins gated in primary mode");
  a_step_latch: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [RULE5]
    i_core_step && !step_q |=> step_ff)
    else $error("step latch missed");
endmodule // fsr_top
`default_nettype wire

// *** verification/fsr_drive_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------
// drive side: idle-high status pins, read pulses
// ------------------------------------------------
module fsr_drive_model (
  // levels and pulse request from the bench
  input  wire logic [2:0] i_lvl,
  input  wire logic       i_pulse,
  input  wire logic       i_slow,
  // drive pins
  output wire logic       o_track_zero_n,
  output wire logic       o_index_pulse_n,
  output wire logic       o_write_protect_n,
  output var  logic       o_read_data_n
);
  assign {o_track_zero_n, o_index_pulse_n, o_write_protect_n} = i_lvl;
  initial o_read_data_n = 1'b1;
  // edges sit off the clock grid on purpose: the pins are asynchronous
  always @(posedge i_pulse) begin
    o_read_data_n <= #13 1'b0;
    o_read_data_n <= #(i_slow ? 413 : 173) 1'b1;
  end
endmodule // fsr_drive_model
`default_nettype wire

// *** verification/floppy_status_output_regs_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module floppy_status_output_regs_tb_top;
  import fsr_pkg::*;
  // ------------------------------------------------
  // stimulus, expected state and scoreboard
  // ------------------------------------------------
  logic       clk = 1'b0, rstn = 1'b0, rd_s = 1'b0, wr_s = 1'b0, pulse = 1'b0, slow = 1'b0;
  logic [1:0] mode = FSR_MODE_PRIMARY;
  logic [9:0] addr = 10'h000;
  logic [7:0] wdata = 8'h00;
  logic       step = 1'b0, dir = 1'b0, head = 1'b0, wg = 1'b0, wd = 1'b0, irq = 1'b0, drq = 1'b0;
  logic [2:0] lvl = 3'h7;
  logic [5:0] drive_output_control = 6'h00;
  logic       step_ff = 1'b0, wg_ff = 1'b0, rd_ff = 1'b0, wd_ff = 1'b0, rtog = 1'b0, wtog = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] vals[5] = '{8'h1C, 8'h2D, 8'h15, 8'hFF, 8'h04};
  logic [6:0] r;
  int         error_cnt = 0, num_checks = 0, seed = 90, low_cnt = 0, low_last = 0, i, j;
  wire  [7:0] rdata;
  wire        oe, ds0_n, ds1_n, mot0_n, mot1_n, srst_n, gate, dreq, dreq_oe, irq_o, irq_oe;
  wire        trk_n, idx_n, wp_n, rdat_n;

  fsr_top DUT (
    .i_sys_clk(clk), .i_rstn(rstn), .i_mode(mode), .i_host_addr(addr), .i_host_rd(rd_s),
    .i_host_wr(wr_s), .i_host_wdata(wdata), .o_host_rdata(rdata), .o_host_rdata_oe(oe),
    .i_core_step(step), .i_core_dir_in(dir), .i_core_head_side_select(head),
    .i_core_write_gate(wg), .i_core_write_data(wd), .i_core_floppy_irq_line(irq),
    .i_core_dma_req(drq), .i_track_zero_n(trk_n), .i_index_pulse_n(idx_n),
    .i_write_protect_n(wp_n), .i_read_data_n(rdat_n), .o_drive_select_out0_n(ds0_n),
    .o_drive_select_out1_n(ds1_n), .o_motor_on_drive0_n(mot0_n),
    .o_motor_on_drive1_n(mot1_n), .o_soft_reset_n(srst_n), .o_dma_pin_gate(gate),
    .o_dma_req(dreq), .o_dma_req_oe(dreq_oe), .o_floppy_irq_line(irq_o),
    .o_floppy_irq_line_oe(irq_oe)
  );
  fsr_drive_model u_drv (
    .i_lvl(lvl), .i_pulse(pulse), .i_slow(slow), .o_track_zero_n(trk_n),
    .o_index_pulse_n(idx_n), .o_write_protect_n(wp_n), .o_read_data_n(rdat_n)
  );

  function automatic logic sel_n(input int d);
    return !(drive_output_control[1:0] == 2'(d) && drive_output_control[4+d]);
  endfunction
  function automatic logic [7:0] exp_a();
    if (mode == FSR_MODE_ALT)
      return {irq, drq, step_ff, ~lvl[2], ~head, ~lvl[1], ~lvl[0], ~dir};
    return {irq, 1'b1, step, lvl[2], head, lvl[1], lvl[0], dir};
  endfunction
  function automatic logic [7:0] exp_b();
    if (mode == FSR_MODE_ALT)
      return {1'b1, sel_n(1), sel_n(0), wd_ff, rd_ff, wg_ff, 2'b11};
    return {2'b11, drive_output_control[0], wtog, rtog, wg, drive_output_control[5:4]};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e, input logic ok);
    tick(1);
    addr = a;
    rd_s = 1'b1;
    if (ok) exp_q.push_back(e);
    tick(1);
    rd_s = 1'b0;
    if (!ok) chk({7'h0, oe}, 8'h00);
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    tick(1);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    tick(1);
    wr_s = 1'b0;
    if (a == ADDR_OUT_CTRL) drive_output_control = d[5:0];
  endtask
  task automatic chk_out();
    logic en;
    tick(6);
    en = (mode == FSR_MODE_PRIMARY) | drive_output_control[3];
    chk({ds1_n, ds0_n, mot1_n, mot0_n, gate, dreq_oe, irq_oe, srst_n},
        {sel_n(1), sel_n(0), ~drive_output_control[5], ~drive_output_control[4], en, en, en, drive_output_control[2]});
    chk({6'h0, dreq, irq_o}, {6'h0, drq, irq});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always #20 clk = ~clk;
  // every answered read takes the oldest expectation
  always @(negedge clk) begin
    if (oe === 1'b1)
      chk(rdata, (exp_q.size() != 0) ? exp_q.pop_front() : 8'hxx);
    if (srst_n === 1'b0)
      low_cnt++;
    else if (low_cnt != 0) begin
      low_last = low_cnt;
      low_cnt = 0;
    end
  end

  initial begin
    tick(20);
    rstn = 1'b1;
    tick(8);
    rd(ADDR_STATUS_A, exp_a(), 1'b1);
    rd(ADDR_STATUS_B, exp_b(), 1'b1);
    rd(ADDR_OUT_CTRL, 8'h00, 1'b1);
    chk_out();
    $display("done: reset defaults");
    for (i = 0; i < 5; i++) begin
      wr(ADDR_OUT_CTRL, vals[i]);
      chk_out();
      rd(ADDR_OUT_CTRL, {2'b00, vals[i][5:0]}, 1'b1);
      mode = FSR_MODE_ALT;
      rd(ADDR_STATUS_B, exp_b(), 1'b1);
      mode = FSR_MODE_PRIMARY;
      rd(ADDR_STATUS_B, exp_b(), 1'b1);
    end
    wr(ADDR_STATUS_A, 8'hFF);
    rd(ADDR_OUT_CTRL, {2'b00, drive_output_control}, 1'b1);
    rd(10'h3F5, 8'h00, 1'b0);
    $display("done: output register");
    for (i = 0; i < 8; i++) begin
      mode = 2'(i);
      if (i == 4) wr(ADDR_OUT_CTRL, 8'h0C);
      chk_out();
      rd(ADDR_STATUS_A, exp_a(), mode inside {2'b01, 2'b10});
      rd(ADDR_STATUS_B, exp_b(), mode inside {2'b01, 2'b10});
    end
    $display("done: modes and gating");
    for (i = 0; i < 12; i++) begin
      r = 7'($random(seed));
      tick(1);
      if (r[0] && !step) step_ff = 1'b1;
      if (r[1] && !wg) wg_ff = 1'b1;
      if (!r[2] && wd) {wd_ff, wtog} = {1'b1, ~wtog};
      {drq, irq, head, dir, wd, wg, step} = r;
      lvl = 3'($random(seed));
      slow = r[3];
      pulse = i[0];
      tick(18);
      if (i[0]) {rd_ff, rtog, pulse} = {1'b1, ~rtog, 1'b0};
      for (j = 1; j < 3; j++) begin
        mode = 2'(j);
        rd(ADDR_STATUS_A, exp_a(), 1'b1);
        rd(ADDR_STATUS_B, exp_b(), 1'b1);
      end
      if (i % 3 == 2) begin
        rd(ADDR_DIG_INPUT, 8'h00, 1'b0);
        {step_ff, wg_ff, rd_ff, wd_ff} = 4'h0;
      end
    end
    $display("done: latches and toggles");
    if (wd) {wd_ff, wtog} = {1'b1, ~wtog};
    {step, wg, wd} = 3'b000;
    tick(2);
    step = 1'b1;
    step_ff = 1'b1;
    wr(ADDR_OUT_CTRL, 8'h1C);
    tick(8);
    rd(ADDR_STATUS_A, exp_a(), 1'b1);
    wr(ADDR_OUT_CTRL, 8'h18);
    tick(1); // keeps the reset bit low longer than its minimum
    wr(ADDR_OUT_CTRL, 8'h1C);
    for (j = 0; j < 30 && srst_n !== 1'b1; j++) tick(1);
    tick(2);
    chk({7'h0, srst_n}, 8'h01);
    chk(8'(low_last >= SOFT_RST_CYC), 8'h01);
    step_ff = 1'b0;
    rd(ADDR_STATUS_A, exp_a(), 1'b1);
    mode = FSR_MODE_PRIMARY;
    rd(ADDR_STATUS_B, exp_b(), 1'b1);
    rd(ADDR_OUT_CTRL, 8'h1C, 1'b1);
    $display("done: controller reset");
    step = 1'b0;
    tick(2);
    rstn = 1'b0;
    tick(3);
    rstn = 1'b1;
    {drive_output_control, step_ff, wg_ff, rd_ff, wd_ff, rtog, wtog} = '0;
    tick(8);
    rd(ADDR_OUT_CTRL, 8'h00, 1'b1);
    rd(ADDR_STATUS_B, exp_b(), 1'b1);
    chk_out();
    tick(2);
    chk(8'(exp_q.size()), 8'h00);
    $display("done: second hardware reset");
    wrap_up();
  end
endmodule // floppy_status_output_regs_tb_top
`default_nettype wire
